/* File: hw/ucdr_pkg.sv */
// Constants, encodings and carrier types of the USB charger detection register bank.
// Assumes a single 40 MHz system clock and byte-wide register access from the host bus controller.
package ucdr_pkg;

	// Register offsets
	localparam logic [7:0] UCDR_OFS_RESULT = 8'h32;
	localparam logic [7:0] UCDR_OFS_CMP = 8'h33;
	localparam logic [7:0] UCDR_OFS_OVP = 8'h34;
	localparam logic [7:0] UCDR_OFS_CTL = 8'h35;
	localparam logic [7:0] UCDR_OFS_DRV = 8'h36;
	localparam logic [7:0] UCDR_OFS_SW = 8'h37;

	// Detection result status fields
	localparam int RES_RUN_BIT = 6;
	localparam int RES_CLASS_LSB = 3;
	localparam int RES_TMO_BIT = 2;
	localparam int RES_PORT_LSB = 0;

	// Line compare status fields
	localparam int CMP_MINUS_DEB = 7;
	localparam int CMP_MINUS_LGC = 5;
	localparam int CMP_MINUS_REF = 4;
	localparam int CMP_PLUS_DEB = 3;
	localparam int CMP_PLUS_LGC = 1;
	localparam int CMP_PLUS_REF = 0;

	// Overvoltage status fields
	localparam int OVP_PLUS_BIT = 1;
	localparam int OVP_MINUS_BIT = 0;

	// Detection control fields
	localparam int CTL_WAIT_BIT = 7;
	localparam int CTL_RELAX_BIT = 5;
	localparam int CTL_HC_BIT = 4;
	localparam int CTL_MAN_BIT = 1;
	localparam int CTL_AUTO_BIT = 0;
	localparam logic [7:0] CTL_RESET = 8'h81;
	localparam logic [7:0] CTL_WMASK = 8'hb1;

	// Line drive control fields
	localparam int DRV_PLUS_MON_BIT = 7;
	localparam int DRV_MINUS_MON_BIT = 5;
	localparam int DRV_OVR_BIT = 4;
	localparam int DRV_PLUS_LSB = 2;
	localparam int DRV_MINUS_LSB = 0;
	localparam logic [7:0] DRV_RESET = 8'h00;
	localparam logic [7:0] DRV_WMASK = 8'hbf;

	// Data switch field
	localparam int SW_LSB = 0;
	localparam logic [1:0] SW_RESET = 2'h0;
	localparam logic [1:0] SW_OPEN = 2'h0;
	localparam logic [1:0] SW_DOWNSTREAM = 2'h1;
	localparam logic [1:0] SW_DETECT = 2'h2;

	// Port type and legacy class encodings
	localparam logic [1:0] PORT_NONE = 2'h0;
	localparam logic [1:0] PORT_SDP = 2'h1;
	localparam logic [1:0] PORT_CDP = 2'h2;
	localparam logic [1:0] PORT_DCP = 2'h3;
	localparam logic [2:0] CLASS_NONE = 3'h0;
	localparam logic [2:0] CLASS_LEGACY_MAX = 3'h5;
	localparam logic [2:0] CLASS_HC_DCP = 3'h6;

	// Line drive condition encodings
	localparam logic [1:0] DRIVE_PULLDOWN = 2'h0;
	localparam logic [1:0] DRIVE_LOW_V = 2'h1;
	localparam logic [1:0] DRIVE_HIGH_V = 2'h2;
	localparam logic [1:0] DRIVE_OPEN = 2'h3;

	// Contact detect wait times
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned WAIT_LONG_MS = 2000;
	localparam int unsigned WAIT_SHORT_MS = 800;
	localparam logic [26:0] WAIT_LONG_CYC = 27'(WAIT_LONG_MS * (CLK_HZ / 1000));
	localparam logic [26:0] WAIT_SHORT_CYC = 27'(WAIT_SHORT_MS * (CLK_HZ / 1000));

	// Detection sequencer states
	typedef enum logic [1:0] {
		UCDR_IDLE,
		UCDR_CONTACT,
		UCDR_CLASSIFY,
		UCDR_DCP_END
	} ucdr_state_t;

	// Comparator, debounce and overvoltage levels from the analog front end
	typedef struct packed {
		logic minus_line_debounce_ok;
		logic minus_line_logic_level;
		logic minus_line_ref_compare;
		logic plus_line_debounce_ok;
		logic plus_line_logic_level;
		logic plus_line_ref_compare;
		logic plus_line_overvoltage;
		logic minus_line_overvoltage;
	} ucdr_analog_t;

	// Classification outcome from the analog classifier
	typedef struct packed {
		logic done;
		logic [1:0] port;
		logic [2:0] legacy;
		logic hc_dcp;
	} ucdr_class_t;

	// Resource settings on the two data lines
	typedef struct packed {
		logic [1:0] plus_line_drive;
		logic [1:0] minus_line_drive;
		logic plus_line_monitor_en;
		logic minus_line_monitor_en;
		logic vdp_src;
	} ucdr_line_t;

endpackage : ucdr_pkg

/* File: hw/ucdr_line_ctl.sv */
// Line resource arbiter: picks sequencer or manual settings for the data lines.
// Assumes charger presence is a synchronous level; everything is released while it is low.
`timescale 1ns/1ps

module ucdr_line_ctl
	import ucdr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Selection inputs
	input wire logic charger_ok,
	input wire logic [7:0] drive_reg,
	input wire ucdr_line_t fsm_line,
	// Registered line settings
	output ucdr_line_t line_out
);

	typedef struct packed {
		ucdr_line_t line;
	} ucdr_lc_state_t;

	ucdr_lc_state_t q;
	ucdr_lc_state_t d;

	// Choose the owner of the line resources
	always_comb begin
		d = q;
		d.line.plus_line_drive = DRIVE_OPEN;
		d.line.minus_line_drive = DRIVE_OPEN;
		d.line.plus_line_monitor_en = 1'b0;
		d.line.minus_line_monitor_en = 1'b0;
		d.line.vdp_src = 1'b0;
		if (charger_ok) begin // [RULE_15]
			d.line.plus_line_monitor_en = drive_reg[DRV_PLUS_MON_BIT]; // [RULE_12]
			d.line.minus_line_monitor_en = drive_reg[DRV_MINUS_MON_BIT]; // [RULE_12]
			if (drive_reg[DRV_OVR_BIT]) begin // [RULE_13]
				d.line.plus_line_drive = drive_reg[DRV_PLUS_LSB +: 2]; // [RULE_14]
				d.line.minus_line_drive = drive_reg[DRV_MINUS_LSB +: 2]; // [RULE_14]
			end else begin
				d.line.plus_line_drive = fsm_line.plus_line_drive;
				d.line.minus_line_drive = fsm_line.minus_line_drive;
				d.line.vdp_src = fsm_line.vdp_src;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '{line: '{DRIVE_OPEN, DRIVE_OPEN, 1'b0, 1'b0, 1'b0}};
		end else begin
			q <= d;
		end
	end

	assign line_out = q.line;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_released_without_supply;
		!charger_ok |=> line_out.plus_line_drive == DRIVE_OPEN
			&& line_out.minus_line_drive == DRIVE_OPEN && !line_out.vdp_src;
	endproperty
	a_released_without_supply: assert property (p_released_without_supply) // [RULE_15]
		else $error("line resources held without charger supply");

	property p_manual_fields;
		charger_ok && drive_reg[DRV_OVR_BIT] |=>
			line_out.plus_line_drive == $past(drive_reg[DRV_PLUS_LSB +: 2])
			&& line_out.minus_line_drive == $past(drive_reg[DRV_MINUS_LSB +: 2]);
	endproperty
	a_manual_fields: assert property (p_manual_fields) // [RULE_14]
		else $error("manual drive fields not applied");

	property p_monitor_follow;
		charger_ok |=> line_out.plus_line_monitor_en == $past(drive_reg[DRV_PLUS_MON_BIT])
			&& line_out.minus_line_monitor_en == $past(drive_reg[DRV_MINUS_MON_BIT]);
	endproperty
	a_monitor_follow: assert property (p_monitor_follow) // [RULE_12]
		else $error("monitor enables do not follow the register");

endmodule : ucdr_line_ctl

/* File: hw/ucdr_regs.sv */
// Register bank and detection sequencer of the USB charger detection unit.
// Assumes a byte register port from the host bus controller and synchronous analog levels.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Bit 6 of result status reads 1 while a detection run is active.
// RULE_02 - Bits 5:3 give legacy adapter class; 6 only for enabled high-current DCP.
// RULE_03 - Bit 2 flags a contact-detect timeout, else stays 0.
// RULE_04 - Bits 1:0 give port type: none, SDP, CDP, DCP.
// RULE_05 - Line compare status shows debounce, logic and reference comparators per line.
// RULE_06 - Overvoltage status shows live plus line bit 1, minus line bit 0.
// RULE_07 - Control bit 7 picks contact wait: 0 gives 2000 ms, 1 gives 800 ms.
// RULE_08 - Control bit 5 clear keeps voltage source on in DCP end state.
// RULE_09 - High-current DCP recognised only with control bit 4 set; default off.
// RULE_10 - Writing control bit 1 requests one manual run once supply present; self-clears.
// RULE_11 - Control bit 0 set starts detection on each rising supply crossing.
// RULE_12 - Line-drive bits 7 and 5 enable reference monitoring per line.
// RULE_13 - Line-drive bit 4 hands line resources from sequencer to manual fields.
// RULE_14 - Manual two-bit fields select pulldown, 0.6 V, 3.0 V or open.
// RULE_15 - Line-drive settings apply only while charger supply is present.
// RULE_16 - Data switch field is bits 1:0, read-write, resets to 00.
// RULE_17 - Switch codes: 00 open, 01 downstream, 10 detection read-only, 11 reserved.
// RULE_18 - SDP or CDP result routes the data lines downstream automatically.
// RULE_19 - Switch writes ignored during a run; each run restores automatic control.
// RULE_20 - Writes to read-only or reserved bits do nothing; reserved bits read zero.
// RULE_21 - Running bit set from run start until results update and run ends.
module ucdr_regs
	import ucdr_pkg::*;
#(
	parameter logic [26:0] WAIT_LONG_LIMIT = WAIT_LONG_CYC,
	parameter logic [26:0] WAIT_SHORT_LIMIT = WAIT_SHORT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	// Analog front end
	input wire logic charger_ok,
	input wire logic contact_ok,
	input wire ucdr_analog_t analog_in,
	input wire ucdr_class_t class_in,
	// Line and switch control
	output ucdr_line_t line_out,
	output logic [1:0] switch_route,
	output logic detect_running
);

	// Whole state of the bank and sequencer
	typedef struct packed {
		ucdr_state_t fsm;
		logic [26:0] wait_cnt;
		logic charger_prev;
		logic man_pend;
		logic [7:0] ctl;
		logic [7:0] drv;
		logic [1:0] sw;
		logic running;
		logic [2:0] legacy;
		logic tmo;
		logic [1:0] port;
		ucdr_analog_t ana;
		logic [7:0] rdata;
		logic rvalid;
	} ucdr_core_t;

	ucdr_core_t q;
	ucdr_core_t d;
	ucdr_line_t fsm_line;
	logic start_auto;
	logic start_man;
	logic go;
	logic man_set;
	logic [26:0] wait_limit;

	// Address match, shared by read and write decode
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	// Legacy class as reported, filtering the high-current case
	function automatic logic [2:0] class_code(input ucdr_class_t c, input logic hc_en);
		class_code = CLASS_NONE;
		if (hc_en && c.hc_dcp && c.port == PORT_DCP) begin
			class_code = CLASS_HC_DCP;
		end else if (c.legacy <= CLASS_LEGACY_MAX) begin
			class_code = c.legacy;
		end
	endfunction : class_code

	// Read data for one offset; unmapped offsets and reserved bits give zero
	function automatic logic [7:0] read_word(input logic [7:0] addr, input ucdr_core_t s);
		logic [7:0] w;
		w = 8'h00;
		if (addr_hit(addr, UCDR_OFS_RESULT)) begin
			w[RES_RUN_BIT] = s.running; // [RULE_01]
			w[RES_CLASS_LSB +: 3] = s.legacy; // [RULE_02]
			w[RES_TMO_BIT] = s.tmo; // [RULE_03]
			w[RES_PORT_LSB +: 2] = s.port; // [RULE_04]
		end else if (addr_hit(addr, UCDR_OFS_CMP)) begin
			w[CMP_MINUS_DEB] = s.ana.minus_line_debounce_ok; // [RULE_05]
			w[CMP_MINUS_LGC] = s.ana.minus_line_logic_level;
			w[CMP_MINUS_REF] = s.ana.minus_line_ref_compare;
			w[CMP_PLUS_DEB] = s.ana.plus_line_debounce_ok;
			w[CMP_PLUS_LGC] = s.ana.plus_line_logic_level;
			w[CMP_PLUS_REF] = s.ana.plus_line_ref_compare;
		end else if (addr_hit(addr, UCDR_OFS_OVP)) begin
			w[OVP_PLUS_BIT] = s.ana.plus_line_overvoltage; // [RULE_06]
			w[OVP_MINUS_BIT] = s.ana.minus_line_overvoltage;
		end else if (addr_hit(addr, UCDR_OFS_CTL)) begin
			w = s.ctl; // Request bit always reads 0 [RULE_10]
		end else if (addr_hit(addr, UCDR_OFS_DRV)) begin
			w = s.drv;
		end else if (addr_hit(addr, UCDR_OFS_SW)) begin
			w[SW_LSB +: 2] = s.sw; // [RULE_16]
		end
		read_word = w;
	endfunction : read_word

	// Start conditions and the active wait limit
	always_comb begin
		man_set = reg_wr_en && addr_hit(reg_addr, UCDR_OFS_CTL) && reg_wr_data[CTL_MAN_BIT];
		start_auto = charger_ok && !q.charger_prev && q.ctl[CTL_AUTO_BIT]; // [RULE_11]
		start_man = q.man_pend && charger_ok; // [RULE_10]
		go = (q.fsm == UCDR_IDLE || q.fsm == UCDR_DCP_END) && (start_auto || start_man);
		wait_limit = q.ctl[CTL_WAIT_BIT] ? WAIT_SHORT_LIMIT : WAIT_LONG_LIMIT; // [RULE_07]
	end

	// Sequencer's own line settings
	always_comb begin
		fsm_line = '{DRIVE_OPEN, DRIVE_OPEN, 1'b0, 1'b0, 1'b0};
		case (q.fsm)
			UCDR_CONTACT: begin
				fsm_line.minus_line_drive = DRIVE_PULLDOWN;
			end
			UCDR_CLASSIFY: begin
				fsm_line.plus_line_drive = DRIVE_LOW_V;
				fsm_line.minus_line_drive = DRIVE_PULLDOWN;
				fsm_line.vdp_src = 1'b1;
			end
			UCDR_DCP_END: begin
				if (!q.ctl[CTL_RELAX_BIT]) begin // [RULE_08]
					fsm_line.plus_line_drive = DRIVE_LOW_V;
					fsm_line.vdp_src = 1'b1;
				end
			end
			default: begin
				fsm_line.plus_line_drive = DRIVE_OPEN;
			end
		endcase
	end

	// Next state of the bank and sequencer
	always_comb begin
		d = q;
		d.rvalid = 1'b0;
		d.ana = analog_in; // Live levels, one flop of delay [RULE_06]
		d.charger_prev = charger_ok;
		// Register writes; read-only offsets and reserved bits are dropped
		if (reg_wr_en) begin // [RULE_20]
			if (addr_hit(reg_addr, UCDR_OFS_CTL)) begin
				d.ctl = reg_wr_data & CTL_WMASK;
				if (reg_wr_data[CTL_MAN_BIT]) begin
					d.man_pend = 1'b1; // [RULE_10]
				end
			end else if (addr_hit(reg_addr, UCDR_OFS_DRV)) begin
				d.drv = reg_wr_data & DRV_WMASK; // [RULE_13]
			end else if (addr_hit(reg_addr, UCDR_OFS_SW)) begin
				// Only open and downstream may be forced, and not mid-run
				if (!q.running && (reg_wr_data[SW_LSB +: 2] == SW_OPEN
						|| reg_wr_data[SW_LSB +: 2] == SW_DOWNSTREAM)) begin // [RULE_17] [RULE_19]
					d.sw = reg_wr_data[SW_LSB +: 2];
				end
			end
		end
		// Supply lost: nothing attached any more
		if (!charger_ok && q.charger_prev) begin
			d.port = PORT_NONE;
			d.legacy = CLASS_NONE;
		end
		// Detection sequencer
		case (q.fsm)
			UCDR_CONTACT: begin
				if (!charger_ok) begin
					d.fsm = UCDR_IDLE;
					d.running = 1'b0;
					d.sw = SW_OPEN;
				end else if (contact_ok) begin
					d.fsm = UCDR_CLASSIFY;
				end else if (q.wait_cnt >= wait_limit - 27'h1) begin
					d.tmo = 1'b1; // [RULE_03]
					d.fsm = UCDR_CLASSIFY;
				end else begin
					d.wait_cnt = q.wait_cnt + 27'h1;
				end
			end
			UCDR_CLASSIFY: begin
				if (!charger_ok) begin
					d.fsm = UCDR_IDLE;
					d.running = 1'b0;
					d.sw = SW_OPEN;
				end else if (class_in.done) begin
					// Results and end of run land on the same edge
					d.port = class_in.port; // [RULE_04]
					d.legacy = class_code(class_in, q.ctl[CTL_HC_BIT]); // [RULE_02] [RULE_09]
					d.running = 1'b0; // [RULE_21]
					if (class_in.port == PORT_SDP || class_in.port == PORT_CDP) begin
						d.sw = SW_DOWNSTREAM; // [RULE_18]
					end else begin
						d.sw = SW_OPEN;
					end
					d.fsm = (class_in.port == PORT_DCP) ? UCDR_DCP_END : UCDR_IDLE;
				end
			end
			UCDR_DCP_END: begin
				if (!charger_ok) begin
					d.fsm = UCDR_IDLE;
				end
			end
			default: begin
				d.fsm = UCDR_IDLE;
			end
		endcase
		// A new run, automatic or manual
		if (go) begin
			d.fsm = UCDR_CONTACT;
			d.running = 1'b1; // [RULE_01] [RULE_21]
			d.tmo = 1'b0;
			d.wait_cnt = 27'h0;
			d.sw = SW_DETECT; // Switch control back to automatic [RULE_19]
			d.man_pend = man_set; // A request written now survives [RULE_10]
		end
		// Registered read answer
		if (reg_rd_en) begin
			d.rvalid = 1'b1;
			d.rdata = read_word(reg_addr, q);
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q.fsm <= UCDR_IDLE;
			q.wait_cnt <= 27'h0;
			q.charger_prev <= 1'b0;
			q.man_pend <= 1'b0;
			q.ctl <= CTL_RESET; // [RULE_07] [RULE_09] [RULE_11]
			q.drv <= DRV_RESET;
			q.sw <= SW_RESET; // [RULE_16]
			q.running <= 1'b0;
			q.legacy <= CLASS_NONE;
			q.tmo <= 1'b0;
			q.port <= PORT_NONE;
			q.ana <= '0;
			q.rdata <= 8'h00;
			q.rvalid <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Line resource arbiter
	ucdr_line_ctl u_line_ctl (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.charger_ok(charger_ok),
		.drive_reg(q.drv),
		.fsm_line(fsm_line),
		.line_out(line_out)
	);

	assign reg_rd_data = q.rdata;
	assign reg_rd_valid = q.rvalid;
	assign switch_route = q.sw;
	assign detect_running = q.running;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_supply_rise_idle;
		charger_ok && !q.charger_prev && q.fsm == UCDR_IDLE;
	endsequence

	sequence s_run_started;
		q.running && q.fsm == UCDR_CONTACT && q.sw == SW_DETECT && !q.tmo;
	endsequence

	property p_run_status;
		q.running == (q.fsm == UCDR_CONTACT || q.fsm == UCDR_CLASSIFY);
	endproperty
	a_run_status: assert property (p_run_status) // [RULE_21]
		else $error("running flag disagrees with sequencer state");

	property p_auto_start;
		s_supply_rise_idle and q.ctl[CTL_AUTO_BIT] |=> s_run_started;
	endproperty
	a_auto_start: assert property (p_auto_start) // [RULE_11]
		else $error("supply rise did not start detection");

	property p_no_auto_start;
		s_supply_rise_idle and !q.ctl[CTL_AUTO_BIT] && !q.man_pend |=> !q.running;
	endproperty
	a_no_auto_start: assert property (p_no_auto_start) // [RULE_11]
		else $error("detection started with automatic start disabled");

	property p_manual_run;
		q.fsm == UCDR_IDLE && q.man_pend && charger_ok |=> s_run_started ##0 !q.man_pend
			|| $past(man_set);
	endproperty
	a_manual_run: assert property (p_manual_run) // [RULE_10]
		else $error("manual request not taken or not cleared");

	property p_request_reads_zero;
		q.rvalid && $past(addr_hit(reg_addr, UCDR_OFS_CTL)) |-> !q.rdata[CTL_MAN_BIT];
	endproperty
	a_request_reads_zero: assert property (p_request_reads_zero) // [RULE_10]
		else $error("manual request bit read back as 1");

	property p_timeout_origin;
		$rose(q.tmo) |-> q.fsm == UCDR_CLASSIFY && $past(q.fsm) == UCDR_CONTACT
			&& $past(q.wait_cnt) == $past(wait_limit) - 27'h1;
	endproperty
	a_timeout_origin: assert property (p_timeout_origin) // [RULE_03] [RULE_07]
		else $error("timeout flag set outside a full contact wait");

	property p_route_downstream;
		q.fsm == UCDR_CLASSIFY && charger_ok && class_in.done && !go
			&& (class_in.port == PORT_SDP || class_in.port == PORT_CDP)
			|=> q.sw == SW_DOWNSTREAM && !q.running ##1 (q.sw != SW_DETECT || q.running);
	endproperty
	a_route_downstream: assert property (p_route_downstream) // [RULE_18]
		else $error("data lines not routed downstream after SDP or CDP");

	property p_switch_write_ignored;
		q.running && charger_ok && !class_in.done && reg_wr_en
			&& addr_hit(reg_addr, UCDR_OFS_SW) |=> q.sw == SW_DETECT;
	endproperty
	a_switch_write_ignored: assert property (p_switch_write_ignored) // [RULE_19]
		else $error("switch write took effect during detection");

	property p_hc_class_only_dcp;
		q.legacy == CLASS_HC_DCP |-> q.port == PORT_DCP;
	endproperty
	a_hc_class_only_dcp: assert property (p_hc_class_only_dcp) // [RULE_02] [RULE_09]
		else $error("high-current class reported without DCP");

	property p_reserved_zero;
		q.rvalid && $past(addr_hit(reg_addr, UCDR_OFS_OVP)) |-> q.rdata[7:2] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // [RULE_20]
		else $error("reserved overvoltage bits read nonzero");

	property p_dcp_end_source;
		q.fsm == UCDR_DCP_END && charger_ok && !q.drv[DRV_OVR_BIT]
			|=> line_out.vdp_src == !$past(q.ctl[CTL_RELAX_BIT]);
	endproperty
	a_dcp_end_source: assert property (p_dcp_end_source) // [RULE_08]
		else $error("voltage source in DCP end state disagrees with control");

endmodule : ucdr_regs

/* File: dv/ucdr_adapter_model.sv */
// Behavioural model of the attached adapter seen through the analog front end.
// Assumes the device drives line_out and detect_running; the bench picks the answers.
`timescale 1ns/1ps

module ucdr_adapter_model
	import ucdr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Device side
	input wire ucdr_line_t line_out,
	input wire logic detect_running,
	// Scenario settings
	input wire logic [1:0] port_cfg,
	input wire logic [2:0] legacy_cfg,
	input wire logic hc_cfg,
	input wire logic [3:0] contact_dly,
	// Levels towards the device
	output logic contact_ok,
	output ucdr_class_t class_in
);
	logic [3:0] cnt_q;

	// Cycles since the run began; a delay of 15 means contact never forms
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !detect_running) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'hf) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	assign contact_ok = detect_running && contact_dly != 4'hf && cnt_q >= contact_dly;

	// Classification answers once the plus line carries the source voltage
	always_comb begin
		class_in.done = detect_running && line_out.vdp_src;
		class_in.port = class_in.done ? port_cfg : ~port_cfg; // Junk when idle
		class_in.legacy = class_in.done ? legacy_cfg : ~legacy_cfg;
		class_in.hc_dcp = class_in.done ? hc_cfg : ~hc_cfg;
	end
endmodule : ucdr_adapter_model

/* File: dv/test_ucdr_regs.sv */
// Self-checking bench of the charger detection register bank.
// Assumes short contact wait limits; reads are checked from a queue of expected bytes.
`timescale 1ns/1ps

module test_ucdr_regs
	import ucdr_pkg::*;
;
	localparam logic [26:0] LONG = 27'd20;
	localparam logic [26:0] SHORT = 27'd8;
	logic sys_clk = 0, sys_rst = 1, reg_wr_en = 0, reg_rd_en = 0, charger_ok = 0;
	logic [7:0] reg_addr = 0, reg_wr_data = 0, reg_rd_data;
	logic reg_rd_valid, contact_ok, detect_running, hc_cfg = 0;
	ucdr_analog_t analog_in = '0;
	ucdr_class_t class_in;
	ucdr_line_t line_out;
	logic [1:0] switch_route, port_cfg = 0;
	logic [2:0] legacy_cfg = 0;
	logic [3:0] contact_dly = 4'h3;
	logic [7:0] exp_q[$];
	logic [15:0] rnd = 16'd54817;
	int err_count = 0, check_count = 0, cyc = 0, k, n0, n1;

	ucdr_regs #(.WAIT_LONG_LIMIT(LONG), .WAIT_SHORT_LIMIT(SHORT)) i_dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.charger_ok(charger_ok), .contact_ok(contact_ok), .analog_in(analog_in),
		.class_in(class_in), .line_out(line_out), .switch_route(switch_route),
		.detect_running(detect_running));

	ucdr_adapter_model i_adapter (.sys_clk(sys_clk), .sys_rst(sys_rst), .line_out(line_out),
		.detect_running(detect_running), .port_cfg(port_cfg), .legacy_cfg(legacy_cfg),
		.hc_cfg(hc_cfg), .contact_dly(contact_dly), .contact_ok(contact_ok),
		.class_in(class_in));

	// Clock generator
	always #12.5 sys_clk = ~sys_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic give_verdict;
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr_en <= 1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr_en <= 0;
	endtask : wr

	// Read pulse; the expected byte waits in the queue for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd_en <= 1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd_en <= 0;
	endtask : rd

	// Bounded wait for the running flag, reporting the cycles spent
	task automatic wait_run(input logic v, output int n);
		n = 0;
		while (detect_running !== v && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		chk(8'(detect_running), 8'(v));
	endtask : wait_run

	task automatic plug;
		@(posedge sys_clk);
		charger_ok <= 1;
	endtask : plug

	task automatic unplug;
		@(posedge sys_clk);
		charger_ok <= 0;
		repeat (2) @(posedge sys_clk);
	endtask : unplug

	// Read answer monitor takes the oldest expectation
	always @(posedge sys_clk) begin
		if (reg_rd_valid === 1'b1) begin
			if (exp_q.size() > 0) chk(reg_rd_data, exp_q.pop_front());
			else chk(8'h00, 8'h01);
		end
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict;
		end
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 0;
		rd(8'h32, 8'h00);
		rd(8'h35, 8'h81);
		rd(8'h36, 8'h00);
		rd(8'h37, 8'h00);
		for (int a = 8'h32; a < 8'h35; a++) wr(8'(a), 8'hff);
		wr(8'h40, 8'hff);
		for (int a = 8'h32; a < 8'h35; a++) rd(8'(a), 8'h00);
		rd(8'h40, 8'h00);
		wr(8'h35, 8'hfd);
		rd(8'h35, 8'hb1);
		wr(8'h35, 8'h81);
		wr(8'h36, 8'hff);
		rd(8'h36, 8'hbf);
		wr(8'h36, 8'h00);
		wr(8'h37, 8'h03);
		rd(8'h37, 8'h00);
		wr(8'h37, 8'h01);
		rd(8'h37, 8'h01);
		chk(8'(switch_route), 8'h01);
		wr(8'h37, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			analog_in <= rnd[7:0];
			repeat (2) @(posedge sys_clk);
			rd(8'h33, {rnd[7], 1'b0, rnd[6:4], 1'b0, rnd[3:2]});
			rd(8'h34, {6'h0, rnd[1:0]});
		end
		for (int p = 0; p < 4; p++) begin
			port_cfg <= 2'(p);
			legacy_cfg <= 3'(p + 1);
			plug();
			wait_run(1, k);
			chk(8'(switch_route), 8'h02);
			rd(8'h32, 8'h40);
			wr(8'h37, 8'h01);
			wait_run(0, k);
			chk(8'(switch_route), (p == 1 || p == 2) ? 8'h01 : 8'h00);
			rd(8'h32, {2'b0, 3'(p + 1), 1'b0, 2'(p)});
			unplug();
		end
		for (int h = 0; h < 2; h++) begin
			wr(8'h35, 8'h81 | 8'(h * 8'h30));
			hc_cfg <= 1;
			legacy_cfg <= 3'h6;
			plug();
			wait_run(1, k);
			wait_run(0, k);
			rd(8'h32, {2'b0, h ? 3'h6 : 3'h0, 3'h3});
			repeat (3) @(posedge sys_clk);
			chk(8'(line_out.vdp_src), 8'(!h));
			unplug();
		end
		port_cfg <= 0;
		legacy_cfg <= 0;
		contact_dly <= 4'hf;
		for (int w = 0; w < 2; w++) begin
			wr(8'h35, {1'(w), 7'h01});
			plug();
			wait_run(1, k);
			wait_run(0, k);
			if (w == 0) n0 = k;
			else n1 = k;
			rd(8'h32, 8'h04);
			unplug();
		end
		// Supply lost mid-run aborts; results stay cleared and the switch opens
		plug();
		wait_run(1, k);
		unplug();
		wait_run(0, k);
		chk(8'(switch_route), 8'h00);
		rd(8'h32, 8'h00);
		wr(8'h37, 8'h02);
		rd(8'h37, 8'h00);
		chk(8'(n0 - n1), 8'(LONG - SHORT));
		contact_dly <= 4'h3;
		port_cfg <= 2'h1;
		wr(8'h35, 8'h80);
		plug();
		repeat (10) @(posedge sys_clk);
		chk(8'(detect_running), 8'h00);
		wr(8'h35, 8'h82);
		wait_run(1, k);
		wait_run(0, k);
		rd(8'h35, 8'h80);
		for (int c = 0; c < 4; c++) begin
			wr(8'h36, {4'hb, 2'(c), 2'(~c)});
			repeat (3) @(posedge sys_clk);
			chk(8'(line_out), {1'b0, 2'(c), 2'(~c), 3'h6});
		end
		unplug();
		chk(8'(line_out), {1'b0, 4'hf, 3'h0});
		repeat (4) @(posedge sys_clk);
		chk(8'(exp_q.size()), 8'h00);
		give_verdict;
	end
endmodule : test_ucdr_regs
